/* inc/cfsb_defs.svh */
`ifndef CFSB_DEFS_SVH
`define CFSB_DEFS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CFSB_CMD_WORD 8'h79
`define CFSB_CMD_VOUT 8'h7A
`define CFSB_CMD_IOUT 8'h7B
`define CFSB_CMD_INPUT 8'h7C

// ----------------------------------------------------------------
// detail register bit positions
// ----------------------------------------------------------------
`define CFSB_VOUT_OVF 7
`define CFSB_VOUT_OVW 6
`define CFSB_VOUT_UVW 5
`define CFSB_VOUT_UVF 4
`define CFSB_VOUT_VMAX 3
`define CFSB_VOUT_TON 2
`define CFSB_IOUT_OCF 7
`define CFSB_IOUT_OCW 5
`define CFSB_INPUT_LOWVIN 3

// ----------------------------------------------------------------
// summary word bit positions (high byte counted within its byte)
// ----------------------------------------------------------------
`define CFSB_LO_OFF 6
`define CFSB_LO_OVF 5
`define CFSB_LO_OCF 4
`define CFSB_LO_TEMP 2
`define CFSB_LO_CML 1
`define CFSB_LO_OTHER 0
`define CFSB_HI_VOLT 7
`define CFSB_HI_CURR 6
`define CFSB_HI_INPUT 5
`define CFSB_HI_VENDOR 4
`define CFSB_HI_PNG 3

// ----------------------------------------------------------------
// implemented bits and reset values
// ----------------------------------------------------------------
`define CFSB_VOUT_IMPL 8'hFC
`define CFSB_IOUT_IMPL 8'hA0
`define CFSB_INPUT_IMPL 8'h08
`define CFSB_STATUS_RST 8'h00
`define CFSB_MASK_RST 8'h00
`define CFSB_MASK_PNG_RST 1'b1

`endif

/* inc/cfsb_pkg.sv */
package cfsb_pkg;

  // ----------------------------------------------------------------
  // input supply tracking, gray coded
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    CFSB_VIN_POWERUP = 1'b0,
    CFSB_VIN_ARMED = 1'b1
  } cfsb_vin_state_type;

  // ----------------------------------------------------------------
  // complete state of the status bank
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] voutStatus;
    logic [7:0] ioutStatus;
    logic [7:0] inputStatus;
    cfsb_vin_state_type vinState;
    logic [7:0] maskVout;
    logic [7:0] maskIout;
    logic [7:0] maskInput;
    logic maskPng;
    logic [15:0] rdData;
    logic rdValid;
    logic rdError;
    logic smbAlert;
    logic powerNotGood;
  } cfsb_state_type;

endpackage : cfsb_pkg

/* hw/cfsb_status_bank.sv */
`timescale 1ns/1ps
`include "cfsb_defs.svh"

module cfsb_status_bank (
  // clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // host command port
  input wire logic [7:0] cmdCode,
  input wire logic rdStb,
  input wire logic wrStb,
  input wire logic maskWrStb,
  input wire logic [7:0] wrData,
  // live output voltage conditions
  input wire logic overVoltFaultLive,
  input wire logic overVoltWarnLive,
  input wire logic underVoltWarnLive,
  input wire logic underVoltFaultLive,
  input wire logic voutAboveCeilingReq,
  input wire logic turnOnTimeoutLive,
  // live output current conditions
  input wire logic overcurrentFaultLive,
  input wire logic overcurrentWarnLive,
  // input supply levels
  input wire logic vinAboveOn,
  input wire logic vinBelowOff,
  // converter and other summaries
  input wire logic converterEnabled,
  input wire logic overTempLive,
  input wire logic temperatureStatusAny,
  input wire logic commMemoryLogicAny,
  input wire logic vendorOverTempFlag,
  input wire logic vendorMinWarnFlag,
  // answers
  output logic [15:0] rdData,
  output logic rdValid,
  output logic rdError,
  output logic smbAlert,
  output logic powerNotGood
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cfsb_pkg::cfsb_state_type state_reg;
  cfsb_pkg::cfsb_state_type state_next;

  logic [7:0] voutSet;
  logic [7:0] ioutSet;
  logic [7:0] inputSet;
  logic [7:0] voutClr;
  logic [7:0] ioutClr;
  logic [7:0] inputClr;
  logic [7:0] inputView;
  logic [7:0] summaryLow;
  logic [7:0] summaryHigh;
  logic pngLive;
  logic voltageSummaryBit;
  logic currentSummaryBit;
  logic inputSummaryBit;
  logic vendorSummaryBit;
  logic anyUnmasked;

  // ----------------------------------------------------------------
  // event capture
  // ----------------------------------------------------------------
  always_comb begin
    voutSet = 8'h00;
    voutSet[`CFSB_VOUT_OVF] = overVoltFaultLive;
    voutSet[`CFSB_VOUT_OVW] = overVoltWarnLive;
    voutSet[`CFSB_VOUT_UVW] = underVoltWarnLive;
    voutSet[`CFSB_VOUT_UVF] = underVoltFaultLive;
    voutSet[`CFSB_VOUT_VMAX] = voutAboveCeilingReq;
    voutSet[`CFSB_VOUT_TON] = turnOnTimeoutLive;
    ioutSet = 8'h00;
    ioutSet[`CFSB_IOUT_OCF] = overcurrentFaultLive;
    ioutSet[`CFSB_IOUT_OCW] = overcurrentWarnLive;
    inputSet = 8'h00;
    // only armed drops latch; power-up period is shown live instead
    if (state_reg.vinState == cfsb_pkg::CFSB_VIN_ARMED) begin
      inputSet[`CFSB_INPUT_LOWVIN] = vinBelowOff;
    end
  end

  // ----------------------------------------------------------------
  // host clears, write one to clear
  // ----------------------------------------------------------------
  always_comb begin
    voutClr = 8'h00;
    ioutClr = 8'h00;
    inputClr = 8'h00;
    if (wrStb) begin
      if (cmdCode == `CFSB_CMD_VOUT) begin
        voutClr = wrData & `CFSB_VOUT_IMPL;
      end else if (cmdCode == `CFSB_CMD_IOUT) begin
        ioutClr = wrData & `CFSB_IOUT_IMPL;
      end else if (cmdCode == `CFSB_CMD_INPUT) begin
        inputClr = wrData & `CFSB_INPUT_IMPL;
      end else begin
        // summary word and unknown codes: writes have no effect
        inputClr = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // live views and summary word
  // ----------------------------------------------------------------
  always_comb begin
    inputView = state_reg.inputStatus;
    if (state_reg.vinState == cfsb_pkg::CFSB_VIN_POWERUP) begin
      inputView[`CFSB_INPUT_LOWVIN] = 1'b1;
    end
    // low input while powering up or dropped below turn-off level
    pngLive = overVoltFaultLive | overVoltWarnLive |
              underVoltWarnLive | underVoltFaultLive |
              turnOnTimeoutLive | overTempLive |
              overcurrentFaultLive | overcurrentWarnLive |
              (state_reg.vinState == cfsb_pkg::CFSB_VIN_POWERUP) |
              vinBelowOff;
    voltageSummaryBit = |state_reg.voutStatus;
    currentSummaryBit = state_reg.ioutStatus[`CFSB_IOUT_OCF] |
                        state_reg.ioutStatus[`CFSB_IOUT_OCW];
    inputSummaryBit = |inputView;
    vendorSummaryBit = vendorOverTempFlag | vendorMinWarnFlag;
    summaryHigh = 8'h00;
    summaryHigh[`CFSB_HI_VOLT] = voltageSummaryBit;
    summaryHigh[`CFSB_HI_CURR] = currentSummaryBit;
    summaryHigh[`CFSB_HI_INPUT] = inputSummaryBit;
    summaryHigh[`CFSB_HI_VENDOR] = vendorSummaryBit;
    summaryHigh[`CFSB_HI_PNG] = pngLive;
    summaryLow = 8'h00;
    summaryLow[`CFSB_LO_OFF] = ~converterEnabled;
    summaryLow[`CFSB_LO_OVF] =
      state_reg.voutStatus[`CFSB_VOUT_OVF];
    summaryLow[`CFSB_LO_OCF] =
      state_reg.ioutStatus[`CFSB_IOUT_OCF];
    summaryLow[`CFSB_LO_TEMP] = temperatureStatusAny;
    summaryLow[`CFSB_LO_CML] = commMemoryLogicAny;
    // reads 1 after reset because the low-input bit starts live
    summaryLow[`CFSB_LO_OTHER] =
      (|(state_reg.voutStatus & ~(8'h01 << `CFSB_VOUT_OVF))) |
      state_reg.ioutStatus[`CFSB_IOUT_OCW] |
      inputView[`CFSB_INPUT_LOWVIN];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdValid = 1'b0;
    state_next.rdError = 1'b0;

    // set wins over a clear in the same cycle
    state_next.voutStatus = ((state_reg.voutStatus & ~voutClr) |
                             voutSet) & `CFSB_VOUT_IMPL;
    state_next.ioutStatus = ((state_reg.ioutStatus & ~ioutClr) |
                             ioutSet) & `CFSB_IOUT_IMPL;
    state_next.inputStatus = ((state_reg.inputStatus & ~inputClr) |
                              inputSet) & `CFSB_INPUT_IMPL;

    case (state_reg.vinState)
      cfsb_pkg::CFSB_VIN_POWERUP: begin
        if (vinAboveOn) begin
          state_next.vinState = cfsb_pkg::CFSB_VIN_ARMED;
        end
      end
      cfsb_pkg::CFSB_VIN_ARMED: begin
        state_next.vinState = cfsb_pkg::CFSB_VIN_ARMED;
      end
      default: begin
        state_next.vinState = cfsb_pkg::CFSB_VIN_POWERUP;
      end
    endcase

    // companion mask bits, loaded by the host through maskWrStb
    if (maskWrStb) begin
      if (cmdCode == `CFSB_CMD_WORD) begin
        state_next.maskPng = wrData[`CFSB_HI_PNG];
      end else if (cmdCode == `CFSB_CMD_VOUT) begin
        state_next.maskVout = wrData & `CFSB_VOUT_IMPL;
      end else if (cmdCode == `CFSB_CMD_IOUT) begin
        state_next.maskIout = wrData & `CFSB_IOUT_IMPL;
      end else if (cmdCode == `CFSB_CMD_INPUT) begin
        state_next.maskInput = wrData & `CFSB_INPUT_IMPL;
      end
    end

    // reads see the contents before any clear of this cycle
    if (rdStb) begin
      state_next.rdValid = 1'b1;
      if (cmdCode == `CFSB_CMD_WORD) begin
        state_next.rdData = {summaryHigh, summaryLow};
      end else if (cmdCode == `CFSB_CMD_VOUT) begin
        state_next.rdData = {8'h00, state_reg.voutStatus};
      end else if (cmdCode == `CFSB_CMD_IOUT) begin
        state_next.rdData = {8'h00, state_reg.ioutStatus};
      end else if (cmdCode == `CFSB_CMD_INPUT) begin
        state_next.rdData = {8'h00, inputView};
      end else begin
        state_next.rdData = 16'h0000;
        state_next.rdError = 1'b1;
      end
    end

    state_next.powerNotGood = pngLive;
    state_next.smbAlert = anyUnmasked;
  end

  // ----------------------------------------------------------------
  // alert, from the post-update bits so a clear releases it at once
  // ----------------------------------------------------------------
  always_comb begin
    // power-up low input is never latched; it alerts here only through pngLive when maskPng is clear
    anyUnmasked =
      (|(state_next.voutStatus & ~state_next.maskVout)) |
      (|(state_next.ioutStatus & ~state_next.maskIout)) |
      (|(state_next.inputStatus & ~state_next.maskInput)) |
      (pngLive & ~state_next.maskPng);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg.voutStatus <= `CFSB_STATUS_RST;
      state_reg.ioutStatus <= `CFSB_STATUS_RST;
      state_reg.inputStatus <= `CFSB_STATUS_RST;
      state_reg.vinState <= cfsb_pkg::CFSB_VIN_POWERUP;
      state_reg.maskVout <= `CFSB_MASK_RST;
      state_reg.maskIout <= `CFSB_MASK_RST;
      state_reg.maskInput <= `CFSB_MASK_RST;
      state_reg.maskPng <= `CFSB_MASK_PNG_RST;
      state_reg.rdData <= 16'h0000;
      state_reg.rdValid <= 1'b0;
      state_reg.rdError <= 1'b0;
      state_reg.smbAlert <= 1'b0;
      state_reg.powerNotGood <= 1'b1;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdData = state_reg.rdData;
  assign rdValid = state_reg.rdValid;
  assign rdError = state_reg.rdError;
  assign smbAlert = state_reg.smbAlert;
  assign powerNotGood = state_reg.powerNotGood;

endmodule : cfsb_status_bank

/* verification/cfsb_status_bank_asserts.sv */
`timescale 1ns/1ps
module cfsb_status_bank_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host side
  input wire logic ce,
  input wire logic [7:0] cmdCode,
  input wire logic rdStb,
  input wire logic wrStb,
  input wire logic [7:0] wrData,
  // conditions
  input wire logic overVoltFaultLive,
  input wire logic overTempLive,
  input wire logic converterEnabled,
  input wire logic vendorOverTempFlag,
  // answers
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  input wire logic rdError,
  input wire logic powerNotGood
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rdTake;
  assign rdTake = ce && rdStb;
  sequence voutRead;
    rdTake && cmdCode == 8'h7A;
  endsequence
  sequence ovfClear;
    ce && wrStb && cmdCode == 8'h7A && wrData[7] && !overVoltFaultLive;
  endsequence
  read_answer_a: assert property (rdTake |=> rdValid)
    else $error("read not answered");
  unmapped_code_a: assert property (rdTake &&
    (cmdCode < 8'h79 || cmdCode > 8'h7C) |=> rdError && rdData == 16'h0000)
    else $error("unmapped read not refused");
  ovf_latch_a: assert property (ce && overVoltFaultLive ##1 voutRead
    |=> rdData[7]) else $error("overvoltage not latched");
  ovf_clear_a: assert property (ovfClear ##1 voutRead
    |=> !rdData[7]) else $error("overvoltage not cleared");
  iout_zero_a: assert property (rdValid &&
    $past(rdTake && cmdCode == 8'h7B) |-> (rdData & 16'hFF5F) == 16'h0000)
    else $error("current status spare bit set");
  png_live_a: assert property (ce && overTempLive |=> powerNotGood)
    else $error("power not good missed");
  off_bit_a: assert property (rdTake && cmdCode == 8'h79 &&
    !converterEnabled |=> rdData[6]) else $error("off bit clear");
  vendor_bit_a: assert property (rdTake && cmdCode == 8'h79 &&
    vendorOverTempFlag |=> rdData[12]) else $error("vendor bit clear");
endmodule : cfsb_status_bank_asserts

/* verification/cfsb_host_model.sv */
`timescale 1ns/1ps
module cfsb_host_model (
  // clock
  input wire logic clk,
  // requests
  output logic ce,
  output logic [7:0] cmdCode,
  output logic rdStb,
  output logic wrStb,
  output logic maskWrStb,
  output logic [7:0] wrData,
  // answers
  input wire logic [15:0] rdData,
  input wire logic rdValid
);
  initial begin
    ce = 1'b1;
    cmdCode = 8'h00;
    rdStb = 1'b0;
    wrStb = 1'b0;
    maskWrStb = 1'b0;
    wrData = 8'h00;
  end
  // released lines carry inverted values so stale data never matches
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    int i;
    cmdCode = c;
    rdStb = 1'b1;
    @(negedge clk);
    rdStb = 1'b0;
    cmdCode = ~c;
    for (i = 0; i < 3 && rdValid !== 1'b1; i++) @(negedge clk);
    if (rdValid !== 1'b1) tb_cfsb_status_bank.hang();
    d = rdData;
  endtask : rd
  task automatic put(input logic [7:0] c, input logic [7:0] v,
                     input logic m);
    cmdCode = c;
    wrData = v;
    wrStb = !m;
    maskWrStb = m;
    @(negedge clk);
    wrStb = 1'b0;
    maskWrStb = 1'b0;
    cmdCode = ~c;
    wrData = ~v;
  endtask : put
endmodule : cfsb_host_model

/* verification/tb_cfsb_status_bank.sv */
`timescale 1ns/1ps
module tb_cfsb_status_bank;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce, rdStb, wrStb, maskWrStb, rdValid, rdError, smbAlert, png;
  logic [7:0] cmdCode, wrData;
  logic [15:0] rdData, d;
  logic [5:0] vLive = 6'h00;
  logic [1:0] iLive = 2'h0;
  logic vinOn = 1'b0, vinOff = 1'b0, enab = 1'b1, oTemp = 1'b0;
  logic [3:0] misc = 4'h0;
  int n_errors = 0;
  int checks_done = 0;
  int b;
  always #4 clk = ~clk;
  cfsb_host_model host (.clk(clk), .ce(ce), .cmdCode(cmdCode),
    .rdStb(rdStb), .wrStb(wrStb), .maskWrStb(maskWrStb), .wrData(wrData),
    .rdData(rdData), .rdValid(rdValid));
  cfsb_status_bank DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .cmdCode(cmdCode), .rdStb(rdStb), .wrStb(wrStb),
    .maskWrStb(maskWrStb), .wrData(wrData),
    .overVoltFaultLive(vLive[5]), .overVoltWarnLive(vLive[4]),
    .underVoltWarnLive(vLive[3]), .underVoltFaultLive(vLive[2]),
    .voutAboveCeilingReq(vLive[1]), .turnOnTimeoutLive(vLive[0]),
    .overcurrentFaultLive(iLive[1]), .overcurrentWarnLive(iLive[0]),
    .vinAboveOn(vinOn), .vinBelowOff(vinOff), .converterEnabled(enab),
    .overTempLive(oTemp), .temperatureStatusAny(misc[3]),
    .commMemoryLogicAny(misc[2]), .vendorOverTempFlag(misc[1]),
    .vendorMinWarnFlag(misc[0]), .rdData(rdData), .rdValid(rdValid),
    .rdError(rdError), .smbAlert(smbAlert), .powerNotGood(png));
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] x,
                     input logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic hang;
    n_errors++;
    end_of_test();
  endtask : hang
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    host.rd(8'h79, d);
    chk("word", 16'h2801, d);
    chk("alert", 16'h0000, {15'h0, smbAlert});
    chk("png", 16'h0001, {15'h0, png});
    vinOn = 1'b1;
    @(negedge clk);
    vinOn = 1'b0;
    host.rd(8'h7C, d);
    chk("input", 16'h0000, d);
    host.rd(8'h79, d);
    chk("word", 16'h0000, d);
    $display("test reset done");
  endtask : t_reset
  task automatic t_vout;
    for (b = 2; b < 8; b++) begin
      vLive[b-2] = 1'b1;
      @(negedge clk);
      vLive = 6'h00;
      host.rd(8'h7A, d);
      chk("vout", 16'h0001 << b, d);
      host.rd(8'h79, d);
      chk("word", b == 7 ? 16'h8020 : 16'h8001, d);
      chk("alert", 16'h0001, {15'h0, smbAlert});
      host.put(8'h79, 8'hFF, 1'b0);
      host.rd(8'h79, d);
      chk("word", b == 7 ? 16'h8020 : 16'h8001, d);
      host.put(8'h7A, 8'hFF, 1'b0);
      host.rd(8'h7A, d);
      chk("vout", 16'h0000, d);
      chk("alert", 16'h0000, {15'h0, smbAlert});
    end
    $display("test vout done");
  endtask : t_vout
  task automatic t_iout;
    for (b = 0; b < 2; b++) begin
      iLive[b] = 1'b1;
      @(negedge clk);
      iLive = 2'h0;
      host.rd(8'h7B, d);
      chk("iout", b ? 16'h0080 : 16'h0020, d);
      host.rd(8'h79, d);
      chk("word", b ? 16'h4010 : 16'h4001, d);
      host.put(8'h7B, 8'hFF, 1'b0);
      host.rd(8'h7B, d);
      chk("iout", 16'h0000, d);
    end
    $display("test iout done");
  endtask : t_iout
  task automatic t_input;
    vinOff = 1'b1;
    @(negedge clk);
    vinOff = 1'b0;
    host.rd(8'h7C, d);
    chk("input", 16'h0008, d);
    chk("alert", 16'h0001, {15'h0, smbAlert});
    host.rd(8'h79, d);
    chk("word", 16'h2001, d);
    host.put(8'h7C, 8'h08, 1'b1);
    host.rd(8'h7C, d);
    chk("alert", 16'h0000, {15'h0, smbAlert});
    host.put(8'h7C, 8'h08, 1'b0);
    host.put(8'h7C, 8'h00, 1'b1);
    host.rd(8'h7C, d);
    chk("input", 16'h0000, d);
    $display("test input done");
  endtask : t_input
  task automatic t_png;
    host.put(8'h79, 8'h00, 1'b1);
    oTemp = 1'b1;
    @(negedge clk);
    host.rd(8'h79, d);
    chk("word", 16'h0800, d);
    chk("alert", 16'h0001, {15'h0, smbAlert});
    oTemp = 1'b0;
    @(negedge clk);
    host.rd(8'h79, d);
    chk("word", 16'h0000, d);
    chk("png", 16'h0000, {15'h0, png});
    chk("alert", 16'h0000, {15'h0, smbAlert});
    host.put(8'h79, 8'h08, 1'b1);
    $display("test png done");
  endtask : t_png
  task automatic t_misc;
    misc = 4'hD;
    enab = 1'b0;
    host.rd(8'h79, d);
    chk("word", 16'h1046, d);
    misc = 4'h2;
    enab = 1'b1;
    host.rd(8'h79, d);
    chk("word", 16'h1000, d);
    misc = 4'h0;
    host.rd(8'h7D, d);
    chk("unmapped", 16'h0000, d);
    $display("test misc done");
  endtask : t_misc
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_vout();
    t_iout();
    t_input();
    t_png();
    t_misc();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    hang();
  end
endmodule : tb_cfsb_status_bank
bind cfsb_status_bank cfsb_status_bank_asserts chk_u (.clk(clk),
  .sys_rst(sys_rst), .ce(ce), .cmdCode(cmdCode), .rdStb(rdStb),
  .wrStb(wrStb), .wrData(wrData), .overVoltFaultLive(overVoltFaultLive),
  .overTempLive(overTempLive), .converterEnabled(converterEnabled),
  .vendorOverTempFlag(vendorOverTempFlag), .rdData(rdData),
  .rdValid(rdValid), .rdError(rdError), .powerNotGood(powerNotGood));
